// >>> common/lmfcs_pkg.sv
/*
 * Constants for the multiframe clock sync and link delay block.
 * Assumes an 8-bit register port with 12-bit addresses.
 */
package lmfcs_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [11:0] OFS_PAIR_SEL   = 12'h008;
	localparam logic [11:0] OFS_A_IRQ_EN   = 12'h021;
	localparam logic [11:0] OFS_B_IRQ_EN   = 12'h022;
	localparam logic [11:0] OFS_A_IRQ_ST   = 12'h025;
	localparam logic [11:0] OFS_B_IRQ_ST   = 12'h026;
	localparam logic [11:0] OFS_ERR_WIN    = 12'h034;
	localparam logic [11:0] OFS_SYNC_CTRL  = 12'h03A;
	localparam logic [11:0] OFS_SYNC_STAT  = 12'h03B;
	localparam logic [11:0] OFS_PHASE_ERR  = 12'h03C;
	localparam logic [11:0] OFS_GLOB_SC    = 12'h301;
	localparam logic [11:0] OFS_L0_DELAY   = 12'h304;
	localparam logic [11:0] OFS_L1_DELAY   = 12'h305;
	localparam logic [11:0] OFS_L0_VAR     = 12'h306;
	localparam logic [11:0] OFS_L1_VAR     = 12'h307;
	localparam logic [11:0] OFS_LINK_SC    = 12'h458;
	localparam logic [11:0] OFS_FRAME_OCT  = 12'h45A;
	// ==========================================================
	// Field positions
	localparam int CTRL_ENABLE  = 7;
	localparam int CTRL_ARM     = 6;
	localparam int CTRL_CLR     = 5;
	localparam int ST_BUSY      = 7;
	localparam int ST_LOCK      = 3;
	localparam int ST_ROT       = 2;
	localparam int ST_WLIM      = 1;
	localparam int ST_TRIP      = 0;
	localparam int LINK_SC_LSB  = 5;
	// ==========================================================
	// Codes and reset values
	localparam logic [3:0] MODE_ONESHOT = 4'h1;
	localparam logic [3:0] MODE_CONT    = 4'h2;
	localparam logic [3:0] MODE_MONITOR = 4'h9;
	localparam logic [2:0] SUBCLASS_1   = 3'h1;
	localparam logic [2:0] FRAME_OCT_1  = 3'h1;
	localparam logic [2:0] FRAME_OCT_2  = 3'h2;
	localparam logic [7:0] REG_RESET    = 8'h00;
	localparam logic [2:0] FRAME_OCT_RST = 3'h2;
	localparam logic [3:0] RBD_MAX      = 4'hA;
	localparam logic [7:0] ROT_CYCLES   = 8'h08;
	localparam int PCLK_PER_4_OCTETS    = 4;
endpackage

// >>> core/lmfcs_sync.sv
/*
 * Multiframe clock sync, alignment-edge phase check, per-link local
 * receive multiframe clock and receive buffer delay release.
 * Assumes clk is the DAC clock; frame and processing clocks are enables.
 * sysref_in is an asynchronous pin; register port is on clk.
 */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Mode field picks one-shot, continuous, monitor
// - Window field sets tolerated phase error
// - Enable bit switches sync logic on
// - One-shot needs arm after enable
// - Busy reads 1 until processing finishes
// - Lock shows alignment after each check
// - Window-limit shows error beyond window
// - Rotation flag sticky, cleared by clear bit
// - Trip flag sticky, cleared by clear bit
// - Pair A events enabled and W1C status
// - Pair B events enabled and W1C status
// - Subclass 0 or 1, global and link
// - Subclass 0 ignores the sysref pin
// - Both pairs share one multiframe phase
// - No sync error report, subclass 0, F=1
// - Local receive clock delayed by lmfc delay
// - Buffer delay 0..10 processing cycles
// - Frames per processing clock equal 4/F
// - One-shot checks first edge, rotates beyond window
// - Continuous checks all edges, ignores during rotation
// - Monitor aligns once, then only measures
// - Arm bit self-clears on an alignment edge
module lmfcs_sync #(
	parameter int FRAME_DIV = 4,
	parameter int K_FRAMES  = 32
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Pin
	input  wire logic        sysref_in,
	// Link timing
	output logic             lmfc_aligned,
	output logic      [1:0]  local_receive_multiframe_clock,
	output logic      [1:0]  buffer_read_release,
	output logic             sync_error_report_en
);
	localparam int MF = FRAME_DIV * K_FRAMES;

	// Counter widths cap the frame divider, the frame count and the multiframe length
	if (FRAME_DIV < 1 || FRAME_DIV > 16 || K_FRAMES < 2 || K_FRAMES > 32 ||
		MF > 128) begin : g_bad_cfg
		$error("lmfcs_sync: unsupported FRAME_DIV or K_FRAMES");
	end

	typedef enum logic [2:0] {S_IDLE, S_WAIT, S_ROT, S_TRACK, S_DONE} lmfcs_state_t;

	// ==========================================================
	// Registers
	logic [7:0]   pair_sel, irq_en_a, irq_en_b, irq_st_a, irq_st_b, err_win_reg;
	logic [3:0]   sync_processing_mode;
	logic         sync_machine_enable, sync_machine_arm;
	logic [2:0]   glob_subclass, link_subclass, frame_octets;
	logic [7:0]   lmfc_delay_value [2];
	logic [7:0]   delay_variation_value [2];
	logic         lock_flag, window_exceeded_flag, clock_rotated_flag, edge_checked_flag;
	logic [7:0]   current_phase_error;
	lmfcs_state_t state;
	logic [7:0]   rot_cnt;

	wire wr_ctrl  = reg_wr && reg_addr == lmfcs_pkg::OFS_SYNC_CTRL;
	wire clear_sticky_flags = wr_ctrl && reg_wdata[lmfcs_pkg::CTRL_CLR];
	// Subclass 2 is not supported, so any code but 1 runs as subclass 0
	wire sc1 = glob_subclass == lmfcs_pkg::SUBCLASS_1;
	// Variation is clamped on write, so a read shows what the buffer uses
	wire [7:0] var_in = (reg_wdata > 8'(lmfcs_pkg::RBD_MAX)) ?
		8'(lmfcs_pkg::RBD_MAX) : reg_wdata;

	always_ff @(posedge clk) begin
		if (srst) begin
			pair_sel             <= lmfcs_pkg::REG_RESET;
			irq_en_a             <= lmfcs_pkg::REG_RESET;
			irq_en_b             <= lmfcs_pkg::REG_RESET;
			err_win_reg          <= lmfcs_pkg::REG_RESET;
			sync_processing_mode <= 4'h0;
			sync_machine_enable  <= 1'b0;
			glob_subclass        <= 3'h0;
			link_subclass        <= 3'h0;
			frame_octets         <= lmfcs_pkg::FRAME_OCT_RST;
			lmfc_delay_value     <= '{8'h00, 8'h00};
			delay_variation_value <= '{8'h00, 8'h00};
		end else if (reg_wr) begin
			case (reg_addr)
				lmfcs_pkg::OFS_PAIR_SEL:  pair_sel <= reg_wdata;
				lmfcs_pkg::OFS_A_IRQ_EN:  irq_en_a <= reg_wdata;
				lmfcs_pkg::OFS_B_IRQ_EN:  irq_en_b <= reg_wdata;
				lmfcs_pkg::OFS_ERR_WIN:   err_win_reg <= reg_wdata;
				lmfcs_pkg::OFS_SYNC_CTRL: begin
					sync_processing_mode <= reg_wdata[3:0];
					sync_machine_enable  <= reg_wdata[lmfcs_pkg::CTRL_ENABLE];
				end
				lmfcs_pkg::OFS_GLOB_SC:   glob_subclass <= reg_wdata[2:0];
				lmfcs_pkg::OFS_LINK_SC:   link_subclass <= reg_wdata[7:5];
				lmfcs_pkg::OFS_FRAME_OCT: frame_octets <= reg_wdata[2:0];
				lmfcs_pkg::OFS_L0_DELAY:  lmfc_delay_value[0] <= reg_wdata;
				lmfcs_pkg::OFS_L1_DELAY:  lmfc_delay_value[1] <= reg_wdata;
				lmfcs_pkg::OFS_L0_VAR:    delay_variation_value[0] <= var_in;
				lmfcs_pkg::OFS_L1_VAR:    delay_variation_value[1] <= var_in;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Sysref pin: three flops, a change counts once two and three agree
	logic [2:0] sref_sync;
	logic       sref_level;
	always_ff @(posedge clk) begin
		if (srst) begin
			sref_sync  <= 3'h0;
			sref_level <= 1'b0;
		end else begin
			sref_sync <= {sref_sync[1:0], sysref_in};
			if (sref_sync[1] == sref_sync[2])
				sref_level <= sref_sync[2];
		end
	end
	wire sref_rise = sref_sync[1] && sref_sync[2] && !sref_level;

	// ==========================================================
	// Multiframe phase, frame and processing clock enables
	logic [3:0] div_cnt;
	logic [4:0] frame_cnt;
	logic [1:0] pclk_cnt;
	logic [6:0] free_cnt;
	logic       rotate_now;
	wire frame_en = div_cnt == 4'(FRAME_DIV - 1);
	// Frames per processing clock is 4/F
	wire [1:0] pclk_last = (frame_octets == lmfcs_pkg::FRAME_OCT_1) ? 2'h3 :
		(frame_octets == lmfcs_pkg::FRAME_OCT_2) ? 2'h1 : 2'h0;
	wire pclk_en = frame_en && pclk_cnt == pclk_last;

	always_ff @(posedge clk) begin
		if (srst) begin
			div_cnt   <= 4'h0;
			frame_cnt <= 5'h00;
			pclk_cnt  <= 2'h0;
		end else if (rotate_now) begin
			// The edge cycle is position zero, so restart one past it
			div_cnt   <= (FRAME_DIV == 1) ? 4'h0 : 4'h1;
			frame_cnt <= (FRAME_DIV == 1) ? 5'h01 : 5'h00;
			pclk_cnt  <= 2'h0;
		end else begin
			div_cnt <= frame_en ? 4'h0 : div_cnt + 4'h1;
			if (frame_en) begin
				frame_cnt <= (frame_cnt == 5'(K_FRAMES - 1)) ? 5'h00 : frame_cnt + 5'h01;
				pclk_cnt  <= pclk_en ? 2'h0 : pclk_cnt + 2'h1;
			end
		end
	end

	// Internal edge for subclass 0, free running at the multiframe period
	always_ff @(posedge clk) begin
		if (srst)
			free_cnt <= 7'h00;
		else
			free_cnt <= (free_cnt == 7'(MF - 1)) ? 7'h00 : free_cnt + 7'h01;
	end
	wire free_wrap = free_cnt == 7'(MF - 1);

	// Sysref is ignored in subclass 0, so the pin may float
	wire align_edge = sc1 ? sref_rise : free_wrap;

	// ==========================================================
	// Phase check
	wire [7:0] pos = 8'(frame_cnt * FRAME_DIV) + 8'(div_cnt);
	wire [7:0] phase_err = (pos < 8'(MF / 2)) ? pos : pos - 8'(MF);
	wire [7:0] abs_err = phase_err[7] ? 8'h00 - phase_err : phase_err;
	wire [2:0] win = err_win_reg[2:0];
	wire in_window = (abs_err <= {5'h00, win});

	wire is_cont = sync_processing_mode == lmfcs_pkg::MODE_CONT;
	wire is_mon  = sync_processing_mode == lmfcs_pkg::MODE_MONITOR;
	// Edges during a rotation are dropped, not queued
	wire check = sync_machine_enable && align_edge &&
		(state == S_WAIT || state == S_TRACK);
	assign rotate_now = check && state == S_WAIT && !in_window;

	always_ff @(posedge clk) begin
		if (srst) begin
			state   <= S_IDLE;
			rot_cnt <= 8'h00;
		end else if (!sync_machine_enable) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE, S_DONE:
					if (is_cont || sync_machine_arm)
						state <= S_WAIT;
				S_WAIT:
					if (rotate_now) begin
						state   <= S_ROT;
						rot_cnt <= lmfcs_pkg::ROT_CYCLES - 8'h01;
					end else if (check)
						state <= is_cont ? S_WAIT : (is_mon ? S_TRACK : S_DONE);
				S_ROT:
					if (rot_cnt == 8'h00)
						state <= is_cont ? S_WAIT : (is_mon ? S_TRACK : S_DONE);
					else
						rot_cnt <= rot_cnt - 8'h01;
				S_TRACK:
					if (is_cont)
						state <= S_WAIT;
					else if (!is_mon)
						state <= S_DONE;
				default: state <= S_IDLE;
			endcase
		end
	end
	wire busy = state == S_WAIT || state == S_ROT;

	// Arm self-clears on an edge; a new arm in that same cycle wins
	always_ff @(posedge clk) begin
		if (srst)
			sync_machine_arm <= 1'b0;
		else if (wr_ctrl && reg_wdata[lmfcs_pkg::CTRL_ARM])
			sync_machine_arm <= 1'b1;
		else if (align_edge && sync_machine_enable)
			sync_machine_arm <= 1'b0;
	end

	// Live and sticky status; a check in the clear cycle still sets
	always_ff @(posedge clk) begin
		if (srst) begin
			lock_flag            <= 1'b0;
			window_exceeded_flag <= 1'b0;
			clock_rotated_flag   <= 1'b0;
			edge_checked_flag    <= 1'b0;
			current_phase_error  <= 8'h00;
		end else begin
			if (check) begin
				lock_flag            <= in_window || rotate_now;
				window_exceeded_flag <= !in_window;
				current_phase_error  <= rotate_now ? 8'h00 : phase_err;
			end
			if (rotate_now)
				clock_rotated_flag <= 1'b1;
			else if (clear_sticky_flags)
				clock_rotated_flag <= 1'b0;
			if (check)
				edge_checked_flag <= 1'b1;
			else if (clear_sticky_flags)
				edge_checked_flag <= 1'b0;
		end
	end

	// Per-pair event bits, W1C; both pairs share one phase
	wire [3:0] events = check ? {in_window || rotate_now, rotate_now, !in_window, 1'b1} : 4'h0;
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_st_a <= 8'h00;
			irq_st_b <= 8'h00;
		end else begin
			irq_st_a[3:0] <= (irq_st_a[3:0] & ~((reg_wr && reg_addr == lmfcs_pkg::OFS_A_IRQ_ST) ?
				reg_wdata[3:0] : 4'h0)) | (events & irq_en_a[3:0] & {4{pair_sel[0]}});
			irq_st_b[3:0] <= (irq_st_b[3:0] & ~((reg_wr && reg_addr == lmfcs_pkg::OFS_B_IRQ_ST) ?
				reg_wdata[3:0] : 4'h0)) | (events & irq_en_b[3:0] & {4{pair_sel[1]}});
		end
	end

	// ==========================================================
	// Local receive multiframe clock and buffer release per link
	logic [3:0] rbd_cnt [2];
	logic [1:0] rbd_run;
	for (genvar l = 0; l < 2; l++) begin : g_link
		wire [4:0] del_mod = 5'(lmfc_delay_value[l] % 8'(K_FRAMES));
		wire       rx_hit  = frame_en && frame_cnt == del_mod;
		wire [3:0] var_clamped = (delay_variation_value[l] > 8'(lmfcs_pkg::RBD_MAX)) ?
			lmfcs_pkg::RBD_MAX : delay_variation_value[l][3:0];
		always_ff @(posedge clk) begin
			if (srst) begin
				local_receive_multiframe_clock[l] <= 1'b0;
				buffer_read_release[l]            <= 1'b0;
				rbd_cnt[l]                        <= 4'h0;
				rbd_run[l]                        <= 1'b0;
			end else begin
				local_receive_multiframe_clock[l] <= rx_hit;
				buffer_read_release[l]            <= 1'b0;
				if (rx_hit) begin
					rbd_cnt[l] <= var_clamped;
					rbd_run[l] <= 1'b1;
				end else if (rbd_run[l] && rbd_cnt[l] == 4'h0) begin
					buffer_read_release[l] <= 1'b1;
					rbd_run[l]             <= 1'b0;
				end else if (rbd_run[l] && pclk_en)
					rbd_cnt[l] <= rbd_cnt[l] - 4'h1;
			end
		end
	end

	// ==========================================================
	// Outputs and read port
	always_ff @(posedge clk) begin
		if (srst) begin
			lmfc_aligned         <= 1'b0;
			sync_error_report_en <= 1'b1;
		end else begin
			lmfc_aligned <= frame_en && frame_cnt == 5'(K_FRAMES - 1);
			sync_error_report_en <= !(!sc1 && frame_octets == lmfcs_pkg::FRAME_OCT_1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
				lmfcs_pkg::OFS_PAIR_SEL:  reg_rdata <= pair_sel;
				lmfcs_pkg::OFS_A_IRQ_EN:  reg_rdata <= irq_en_a;
				lmfcs_pkg::OFS_B_IRQ_EN:  reg_rdata <= irq_en_b;
				lmfcs_pkg::OFS_A_IRQ_ST:  reg_rdata <= irq_st_a;
				lmfcs_pkg::OFS_B_IRQ_ST:  reg_rdata <= irq_st_b;
				lmfcs_pkg::OFS_ERR_WIN:   reg_rdata <= err_win_reg;
				lmfcs_pkg::OFS_SYNC_CTRL: reg_rdata <= {sync_machine_enable, sync_machine_arm,
					2'b00, sync_processing_mode};
				lmfcs_pkg::OFS_SYNC_STAT: reg_rdata <= {busy, 3'b000, lock_flag,
					clock_rotated_flag, window_exceeded_flag, edge_checked_flag};
				lmfcs_pkg::OFS_PHASE_ERR: reg_rdata <= current_phase_error;
				lmfcs_pkg::OFS_GLOB_SC:   reg_rdata <= {5'h00, glob_subclass};
				lmfcs_pkg::OFS_LINK_SC:   reg_rdata <= {link_subclass, 5'h00};
				lmfcs_pkg::OFS_FRAME_OCT: reg_rdata <= {5'h00, frame_octets};
				lmfcs_pkg::OFS_L0_DELAY:  reg_rdata <= lmfc_delay_value[0];
				lmfcs_pkg::OFS_L1_DELAY:  reg_rdata <= lmfc_delay_value[1];
				lmfcs_pkg::OFS_L0_VAR:    reg_rdata <= delay_variation_value[0];
				lmfcs_pkg::OFS_L1_VAR:    reg_rdata <= delay_variation_value[1];
				default:                  reg_rdata <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	busy_state_a: assert property (rotate_now |=> (busy || !sync_machine_enable) [*8])
		else $error("busy dropped during a rotation");
	trip_set_a: assert property (check |=> edge_checked_flag)
		else $error("trip flag not set after a check");
	sticky_clear_a: assert property (clear_sticky_flags && !check && !rotate_now
		|=> !edge_checked_flag && !clock_rotated_flag)
		else $error("sticky flags not cleared");
	window_flag_a: assert property (check |=> window_exceeded_flag == !$past(in_window))
		else $error("window flag wrong after check");
	lock_flag_a: assert property (check && in_window |=> lock_flag)
		else $error("lock flag not set when in window");
	arm_clear_a: assert property (align_edge && sync_machine_enable && sync_machine_arm
		&& !wr_ctrl |=> !sync_machine_arm)
		else $error("arm bit did not self-clear");
	rot_ignore_a: assert property (rotate_now |=> !check [*8])
		else $error("edge checked during rotation");
	sc0_pin_a: assert property (!sc1 && sync_machine_arm && !free_wrap && !wr_ctrl
		|=> sync_machine_arm)
		else $error("sysref used in subclass 0");
	monitor_hold_a: assert property (state == S_TRACK && check
		|=> current_phase_error == $past(phase_err))
		else $error("monitor mode rotated the clock");
	irq_a_set_a: assert property (check && irq_en_a[0] && pair_sel[0] |=> irq_st_a[0])
		else $error("pair A trip event lost");
	release_a: assert property (local_receive_multiframe_clock[0]
		&& delay_variation_value[0] == 8'h00 |=> buffer_read_release[0])
		else $error("zero delay release late");
	report_a: assert property (!sc1 && frame_octets == lmfcs_pkg::FRAME_OCT_1
		|=> !sync_error_report_en)
		else $error("error report enabled for subclass 0 F=1");

	oneshot_c: cover property (state == S_WAIT && !is_cont && rotate_now);
	cont_c: cover property (is_cont && check ##[1:300] check);
	monitor_c: cover property (state == S_TRACK && check && !in_window);
endmodule

`default_nettype wire

// >>> verification/lmfcs_sysref_src.sv
/*
 * Behavioural alignment-pulse source standing in for the clock source.
 * Assumes the bench asks for a pulse with a one-cycle fire strobe on clk.
 */
`timescale 1ns/100ps
`default_nettype none

module lmfcs_sysref_src (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Request from the bench
	input  wire logic       fire,
	input  wire logic [3:0] lag,
	// Pin
	output logic            sysref
);
	// ==========================================================
	// Pulse timing
	logic [4:0] wait_cnt;
	logic [1:0] hi_cnt;

	// Fixed latency per lag keeps edge phase repeatable across pulses
	always_ff @(posedge clk) begin
		if (srst) begin
			wait_cnt <= 5'h00;
			hi_cnt   <= 2'h0;
		end else begin
			if (fire)
				wait_cnt <= {1'b0, lag} + 5'h01;
			else if (wait_cnt != 5'h00)
				wait_cnt <= wait_cnt - 5'h01;
			if (wait_cnt == 5'h01)
				hi_cnt <= 2'h2;
			else if (hi_cnt != 2'h0)
				hi_cnt <= hi_cnt - 2'h1;
		end
	end

	// Pin rests low between pulses; in subclass 0 no pulse is asked for
	assign sysref = (hi_cnt != 2'h0);
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
/*
 * Self-checking bench for the sync block: register tasks, queued read checks.
 * Assumes one 100 MHz clock and short frame and multiframe counts.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	localparam int FD = 2;
	localparam int KF = 4;
	localparam int MF = FD * KF;
	localparam logic [11:0] ROFS [10] = '{lmfcs_pkg::OFS_PAIR_SEL, lmfcs_pkg::OFS_A_IRQ_EN,
		lmfcs_pkg::OFS_B_IRQ_EN, lmfcs_pkg::OFS_ERR_WIN, lmfcs_pkg::OFS_GLOB_SC,
		lmfcs_pkg::OFS_L0_DELAY, lmfcs_pkg::OFS_L1_DELAY, lmfcs_pkg::OFS_L0_VAR,
		lmfcs_pkg::OFS_L1_VAR, lmfcs_pkg::OFS_LINK_SC};
	localparam logic [7:0] RMSK [10] = '{8'h03, 8'h0F, 8'h0F, 8'h07, 8'h07, 8'h03, 8'h03,
		8'h07, 8'h07, 8'hE0};
	localparam logic [11:0] CTRL = lmfcs_pkg::OFS_SYNC_CTRL;
	localparam logic [11:0] STAT = lmfcs_pkg::OFS_SYNC_STAT;
	// ==========================================================
	// Signals
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        sysref;
	logic        fire = 1'b0;
	logic [3:0]  lag = 4'h0;
	logic        lmfc_aligned;
	logic [1:0]  lrmc;
	logic [1:0]  rel;
	logic        err_en;
	logic        rd_seen = 1'b0;
	logic [15:0] notes [$];
	logic [15:0] note;
	logic [7:0]  v;
	wire  [4:0]  pv = {rel, lmfc_aligned, lrmc};
	int          errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          t0 = 0;
	int          seed = 74132;
	int          n;

	lmfcs_sync #(.FRAME_DIV(FD), .K_FRAMES(KF)) i_lmfcs_sync (.clk(clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sysref_in(sysref), .lmfc_aligned(lmfc_aligned),
		.local_receive_multiframe_clock(lrmc), .buffer_read_release(rel),
		.sync_error_report_en(err_en));
	lmfcs_sysref_src i_lmfcs_sysref_src (.clk(clk), .srst(srst), .fire(fire), .lag(lag),
		.sysref(sysref));

	always #5 clk = ~clk;
	// ==========================================================
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Expected value is noted with its mask; the watcher compares later
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		notes.push_back({e & m, m});
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	// Pulse request placed at a chosen cycle phase of the multiframe
	task automatic sref(input int ph);
		@(posedge clk);
		while (((cyc - t0) % MF) != ph)
			@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask

	task automatic gap(input int a, input int b, output int cnt);
		cnt = 0;
		while (!pv[a] && cnt < 100) begin
			@(posedge clk);
			cnt++;
		end
		cnt = 0;
		do begin
			@(posedge clk);
			cnt++;
		end while (!pv[b] && cnt < 100);
	endtask

	task automatic test_done;
		$display("Comparisons %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Watcher and timeout
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rd_seen <= reg_rd;
		if (cyc == 5000) begin
			errors++;
			test_done();
		end
	end

	always @(negedge clk) begin
		if (rd_seen) begin
			note = notes.pop_front();
			chk(reg_rdata & note[7:0], note[15:8]);
		end
	end
	// ==========================================================
	// Scenarios
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rd(STAT, lmfcs_pkg::REG_RESET, 8'hFF);
		rd(lmfcs_pkg::OFS_FRAME_OCT, 8'({1'b0, lmfcs_pkg::FRAME_OCT_RST}), 8'h07);
		for (int i = 0; i < 10; i++)
			rd(ROFS[i], lmfcs_pkg::REG_RESET, 8'hFF);
		for (int i = 0; i < 10; i++) begin
			v = 8'($random(seed)) & RMSK[i];
			wr(ROFS[i], v);
			rd(ROFS[i], v, RMSK[i]);
		end
		wr(lmfcs_pkg::OFS_L0_VAR, 8'h0C);
		rd(lmfcs_pkg::OFS_L0_VAR, 8'({4'h0, lmfcs_pkg::RBD_MAX}), 8'hFF);
		wr(12'h123, 8'hFF);
		rd(12'h123, 8'h00, 8'hFF);
		// Error reporting against subclass and octets per frame
		wr(lmfcs_pkg::OFS_GLOB_SC, 8'h00);
		wr(lmfcs_pkg::OFS_FRAME_OCT, 8'({1'b0, lmfcs_pkg::FRAME_OCT_1}));
		repeat (2) @(posedge clk);
		chk(8'(err_en), 8'h00);
		wr(lmfcs_pkg::OFS_FRAME_OCT, 8'({1'b0, lmfcs_pkg::FRAME_OCT_2}));
		repeat (2) @(posedge clk);
		chk(8'(err_en), 8'h01);
		wr(lmfcs_pkg::OFS_PAIR_SEL, 8'h03);
		wr(lmfcs_pkg::OFS_A_IRQ_EN, 8'h0F);
		wr(lmfcs_pkg::OFS_B_IRQ_EN, 8'h0F);
		wr(lmfcs_pkg::OFS_ERR_WIN, 8'h01);
		// Subclass 0 one-shot: internal edge, pin left quiet
		wr(CTRL, 8'h81);
		wr(CTRL, 8'hC1);
		repeat (3 * MF) @(posedge clk);
		rd(STAT, 8'h01, 8'h81);
		rd(CTRL, 8'h00, 8'h40);
		wr(CTRL, 8'hA1);
		rd(STAT, 8'h00, 8'h05);
		wr(lmfcs_pkg::OFS_A_IRQ_ST, 8'h0F);
		wr(lmfcs_pkg::OFS_B_IRQ_ST, 8'h0F);
		// Subclass 1 one-shot with a slow source
		wr(lmfcs_pkg::OFS_GLOB_SC, 8'({5'h00, lmfcs_pkg::SUBCLASS_1}));
		lag <= 4'h5;
		wr(CTRL, 8'h81);
		wr(CTRL, 8'hC1);
		rd(STAT, 8'h80, 8'h81);
		rd(CTRL, 8'h40, 8'h40);
		sref(0);
		repeat (30) @(posedge clk);
		rd(STAT, 8'h09, 8'h89);
		rd(CTRL, 8'h00, 8'h40);
		rd(lmfcs_pkg::OFS_A_IRQ_ST, 8'h09, 8'h09);
		rd(lmfcs_pkg::OFS_B_IRQ_ST, 8'h09, 8'h09);
		wr(lmfcs_pkg::OFS_A_IRQ_ST, 8'h0F);
		rd(lmfcs_pkg::OFS_A_IRQ_ST, 8'h00, 8'h01);
		wr(CTRL, 8'hA1);
		rd(STAT, 8'h00, 8'h05);
		sref(0);
		repeat (30) @(posedge clk);
		rd(STAT, 8'h00, 8'h01);
		// Monitor mode: align once, then only measure
		// A zero window forces the first edge onto phase zero
		wr(lmfcs_pkg::OFS_ERR_WIN, 8'h00);
		lag <= 4'h0;
		wr(CTRL, 8'h89);
		wr(CTRL, 8'hC9);
		sref(0);
		t0 = cyc - 1;
		repeat (30) @(posedge clk);
		wr(CTRL, 8'hA9);
		sref(0);
		repeat (30) @(posedge clk);
		rd(STAT, 8'h09, 8'h0F);
		rd(lmfcs_pkg::OFS_PHASE_ERR, 8'h00, 8'hFF);
		sref(3);
		repeat (30) @(posedge clk);
		rd(STAT, 8'h03, 8'h0F);
		rd(lmfcs_pkg::OFS_PHASE_ERR, 8'h03, 8'hFF);
		// Continuous: every edge checked, edges during rotation ignored
		wr(CTRL, 8'hA2);
		sref(3);
		t0 = cyc - 1;
		sref(5);
		repeat (30) @(posedge clk);
		rd(STAT, 8'h0F, 8'h0F);
		rd(lmfcs_pkg::OFS_PHASE_ERR, 8'h00, 8'hFF);
		sref(0);
		repeat (30) @(posedge clk);
		rd(STAT, 8'h8D, 8'h8F);
		// Local receive multiframe clocks per link
		wr(lmfcs_pkg::OFS_L0_DELAY, 8'h01);
		wr(lmfcs_pkg::OFS_L1_DELAY, 8'h03);
		wr(lmfcs_pkg::OFS_L0_VAR, 8'h01);
		repeat (2 * MF) @(posedge clk);
		gap(0, 1, n);
		chk(8'(n), 8'(2 * FD));
		gap(0, 0, n);
		chk(8'(n), 8'(MF));
		gap(2, 2, n);
		chk(8'(n), 8'(MF));
		// Release trails the local clock by one cycle plus the variation in processing clocks
		gap(0, 3, n);
		chk(8'(n), 8'(1 + (4 / 2) * FD));
		// Same delay on both links puts both local clocks on one edge
		wr(lmfcs_pkg::OFS_L0_DELAY, 8'h02);
		wr(lmfcs_pkg::OFS_L1_DELAY, 8'h02);
		repeat (MF) @(posedge clk);
		gap(0, 1, n);
		chk(8'(n), 8'(MF));
		repeat (4) @(posedge clk);
		test_done();
	end
endmodule

`default_nettype wire
